//--- include/cmx_pkg.sv
`default_nettype none

// Shared types and constants for the clock selector and fanout
package cmx_pkg;

    // One differential pair: true and complement leg
    typedef struct packed {
        logic t;
        logic c;
    } cmx_diff_s;

    // Raw control pins together with their driven flags
    typedef struct packed {
        logic sel;
        logic sel_driven;
        logic en;
        logic en_driven;
    } cmx_ctrl_s;

    // Number of fanout pairs
    localparam int CMX_NUM_OUT = 4;
    // Width of the raw pin bundle passed through the synchroniser
    localparam int CMX_PIN_W = 8;
    // Levels an open control pin settles to through its pull resistor
    localparam logic CMX_SEL_OPEN = 1'h0;
    localparam logic CMX_EN_OPEN = 1'h1;
    // Select codes
    localparam logic CMX_SEL_PRIMARY = 1'h0;
    localparam logic CMX_SEL_ALTERNATE = 1'h1;
    // Gate state after reset: outputs parked
    localparam logic CMX_GATE_RST = 1'h0;
    // Parked output pair: true low, complement high
    localparam cmx_diff_s CMX_PARKED = '{t: 1'h0, c: 1'h1};

    // Enable tracker: waits for a rise, then a fall, of the chosen clock
    typedef enum logic [1:0] {
        CMX_IDLE,
        CMX_WAIT_RISE,
        CMX_WAIT_FALL
    } cmx_gate_e;

endpackage

`default_nettype wire

//--- logic/cmx_fanout.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Select low routes primary pair, select high routes alternate pair
// - Undriven select reads low, so primary clock is chosen
// - Enable high passes the clock; undriven enable reads high
// - Enable low parks every pair: true low, complement high
// - Four identical pairs; true follows clock, complement is its inverse
// - Gate changes only while the selected clock is low
// - Enable is captured on the falling edge of the selected clock
// - After enable changes, a rise then a fall must pass before switching
module cmx_fanout
    import cmx_pkg::*;
#(
    parameter int NUM_OUT = CMX_NUM_OUT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire cmx_diff_s prim_clk_in,
    input wire cmx_diff_s alt_clk_in,
    input wire cmx_ctrl_s ctrl_in,
    output cmx_diff_s fanout_output_0,
    output cmx_diff_s fanout_output_1,
    output cmx_diff_s fanout_output_2,
    output cmx_diff_s fanout_output_3
);

    // Only four pairs are wired out, so any other count is refused
    if (NUM_OUT != CMX_NUM_OUT) begin : g_num_out_bad
        $error("cmx_fanout: exactly four output pairs are wired out");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [CMX_PIN_W-1:0] pins_raw;
    logic [CMX_PIN_W-1:0] pins_s;
    cmx_diff_s prim_s;
    cmx_diff_s alt_s;
    cmx_ctrl_s ctrl_s;

    assign pins_raw = {prim_clk_in, alt_clk_in, ctrl_in};
    assign {prim_s, alt_s, ctrl_s} = pins_s;

    cmx_sync #(
        .WIDTH(CMX_PIN_W)
    ) u_sync (
        .clk(clk),
        .din(pins_raw),
        .dout(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Input decode and source selection

    wire prim_lvl;
    wire alt_lvl;
    wire sel_eff;
    wire en_eff;
    wire sel_lvl;

    // A floating pair is pulled to true low, complement high, so it reads 0
    assign prim_lvl = prim_s.t & ~prim_s.c;
    assign alt_lvl = alt_s.t & ~alt_s.c;
    // Open control pins take their pull level
    assign sel_eff = ctrl_s.sel_driven ? ctrl_s.sel : CMX_SEL_OPEN;
    assign en_eff = ctrl_s.en_driven ? ctrl_s.en : CMX_EN_OPEN;
    // Select is assumed static; a live change may chop a pulse
    assign sel_lvl = (sel_eff == CMX_SEL_ALTERNATE)
        ? alt_lvl : prim_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the selected clock

    logic lvl_prev;
    wire rise;
    wire fall;

    assign rise = sel_lvl & ~lvl_prev;
    assign fall = ~sel_lvl & lvl_prev;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lvl_prev <= CMX_PARKED.t; // Idle pin level, so no false edge
        end else begin
            lvl_prev <= sel_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable tracker and gate flop

    cmx_gate_e state;
    cmx_gate_e next_state;
    logic gate_en;
    wire differs;
    wire take;

    assign differs = en_eff != gate_en;
    // Taking only on a fall means the clock is low when the gate moves
    assign take = (state == CMX_WAIT_FALL) && fall && differs;

    // A new enable level must see a full rise and fall before it acts
    always_comb begin
        next_state = state;
        case (state)
            CMX_IDLE: begin
                if (differs) begin
                    next_state = CMX_WAIT_RISE;
                end
            end
            CMX_WAIT_RISE: begin
                if (!differs) begin
                    next_state = CMX_IDLE;
                end else if (rise) begin
                    next_state = CMX_WAIT_FALL;
                end
            end
            CMX_WAIT_FALL: begin
                if (!differs || fall) begin
                    next_state = CMX_IDLE;
                end
            end
            default: begin
                next_state = CMX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= CMX_IDLE;
            gate_en <= CMX_GATE_RST;
        end else begin
            state <= next_state;
            if (take) begin
                gate_en <= en_eff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fanout pairs

    cmx_diff_s outs [NUM_OUT];
    wire gated;

    assign gated = sel_lvl & gate_en;

    // One flop pair per output keeps each pair's skew equal
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                outs[i] <= CMX_PARKED;
            end else begin
                outs[i].t <= gated;
                outs[i].c <= ~gated;
            end
        end
    end

    assign fanout_output_0 = outs[0];
    assign fanout_output_1 = outs[1];
    assign fanout_output_2 = outs[2];
    assign fanout_output_3 = outs[3];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_primary_route: assert property (
        gate_en && sel_eff == CMX_SEL_PRIMARY
        |=> fanout_output_0.t == $past(prim_lvl) || $changed(gate_en))
    else $error("primary clock not routed");

    chk_alt_route: assert property (
        gate_en && sel_eff == CMX_SEL_ALTERNATE
        |=> fanout_output_0.t == $past(alt_lvl) || $changed(gate_en))
    else $error("alternate clock not routed");

    chk_sel_open_default: assert property (
        !ctrl_s.sel_driven |=> fanout_output_1.t == $past(prim_lvl & gate_en))
    else $error("open select did not pick primary");

    chk_en_open_hold: assert property (
        !ctrl_s.en_driven && gate_en |=> gate_en)
    else $error("open enable turned outputs off");

    chk_parked_off: assert property (
        !gate_en ##1 !gate_en
        |-> fanout_output_2 == CMX_PARKED && fanout_output_3 == CMX_PARKED)
    else $error("disabled outputs not parked");

    chk_pairs_equal: assert property (
        fanout_output_0 == fanout_output_3
        && fanout_output_1 == fanout_output_2
        && fanout_output_0 == fanout_output_1
        && fanout_output_0.c == ~fanout_output_0.t)
    else $error("output pairs disagree");

    chk_gate_low_out: assert property (
        $changed(gate_en) |-> !fanout_output_0.t && !$past(gated))
    else $error("gate moved while output high");

    chk_gate_on_fall: assert property (
        $changed(gate_en) |-> $past(fall) && !$past(sel_lvl))
    else $error("gate moved off a falling edge");

    chk_rise_then_fall: assert property (
        $changed(gate_en) |-> $past(state) == CMX_WAIT_FALL)
    else $error("gate moved without rise then fall");

    chk_out_gated: assert property (
        fanout_output_0.t |-> $past(gate_en) && $past(sel_lvl))
    else $error("output high without gate and clock");

    cov_enable_on: cover property (
        !gate_en ##1 gate_en ##[1:20] fanout_output_0.t);
    cov_disable: cover property (gate_en ##1 !gate_en);
    cov_alt_running: cover property (
        sel_eff == CMX_SEL_ALTERNATE && fanout_output_0.t);
    cov_abort_wait: cover property (
        state == CMX_WAIT_RISE ##1 state == CMX_IDLE && !differs);

endmodule

`default_nettype wire

//--- logic/cmx_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for a bundle of pin levels
module cmx_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        stage1 <= din;
        dout <= stage1;
    end

    // An empty bundle has nothing to carry, so it is refused at elaboration
    if (WIDTH < 1) begin : g_width_bad
        $error("cmx_sync: WIDTH must be at least 1");
    end

endmodule

`default_nettype wire

//--- test/cmx_clk_src.sv
`timescale 1ns/1ps
`default_nettype none

// Upstream differential clock, half period counted in clk cycles
module cmx_clk_src
    import cmx_pkg::*;
#(
    parameter int HALF = 6
) (
    input wire logic clk,
    input wire logic float_pin,
    output var cmx_diff_s pin
);
    logic [7:0] cnt = 8'h00;
    logic lvl = 1'h0;

    // Free running source; slow enough for the sampled model to see edges
    always_ff @(posedge clk) begin
        cnt <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'(HALF - 1)) begin
            lvl <= ~lvl;
        end
    end

    // An open pair settles to its pulls: true low, complement high
    assign pin = float_pin ? CMX_PARKED
        : cmx_diff_s'{t: lvl, c: ~lvl};
endmodule

`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import cmx_pkg::*;
;
    localparam int P_HALF = 6;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [3:0] ctrl_in = 4'h0; // Order: sel, sel_driven, en, en_driven
    logic prim_float = 1'h0;
    logic alt_float = 1'h0;
    logic [2:0] hist = 3'h0;
    int err_total = 0;
    int tests_run = 0;
    cmx_diff_s prim_clk_in, alt_clk_in, o0, o1, o2, o3;
    wire logic [7:0] outs = {o3, o2, o1, o0};
    wire logic sel_lvl = ctrl_in[3] & ctrl_in[2];
    wire cmx_diff_s src = sel_lvl ? alt_clk_in : prim_clk_in;

    always #10 clk = ~clk;

    // Selected pin level, aged to match the three flop latency
    always @(posedge clk) hist <= {hist[1:0], src.t & ~src.c};

    cmx_clk_src #(.HALF(P_HALF)) i_cmx_clk_src_0 (.clk(clk),
        .float_pin(prim_float), .pin(prim_clk_in));
    cmx_clk_src #(.HALF(10)) i_cmx_clk_src_1 (.clk(clk),
        .float_pin(alt_float), .pin(alt_clk_in));
    cmx_fanout i_cmx_fanout (.clk(clk), .sys_rst(sys_rst),
        .prim_clk_in(prim_clk_in), .alt_clk_in(alt_clk_in),
        .ctrl_in(ctrl_in), .fanout_output_0(o0), .fanout_output_1(o1),
        .fanout_output_2(o2), .fanout_output_3(o3));

    task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // All four pairs against the aged source, gated by en
    task automatic follow(input int n, input logic en);
        repeat (n) begin
            @(posedge clk);
            #1;
            cmp(outs, {4{en & hist[2], ~(en & hist[2])}});
        end
    endtask

    // Settle long enough for sync plus a rise and a fall of either source
    task automatic set_ctrl(input logic [3:0] v);
        @(posedge clk);
        ctrl_in <= v;
        repeat (48) @(posedge clk);
    endtask

    // Change enable just after a fall; time the next fresh output pulse
    task automatic gate_step(input logic en_val, output int d, output int w);
        @(negedge prim_clk_in.t);
        @(posedge clk);
        ctrl_in <= {2'h1, en_val, 1'h1};
        d = 0;
        w = 0;
        #1;
        // The tail of the pulse already in flight is not the one timed
        while (o0.t === 1'h1 && d < 60) begin
            @(posedge clk);
            #1;
            d++;
        end
        while (o0.t !== 1'h1 && d < 60) begin
            @(posedge clk);
            #1;
            d++;
        end
        while (o0.t === 1'h1 && w < 60) begin
            @(posedge clk);
            #1;
            w++;
        end
    endtask

    task automatic t_select;
        set_ctrl(4'h0);
        follow(36, 1'h1);
        set_ctrl(4'h8);
        follow(36, 1'h1);
        set_ctrl(4'h7);
        follow(36, 1'h1);
        set_ctrl(4'hF);
        follow(48, 1'h1);
        $display("select test done");
    endtask

    // Disable and enable must each emit only whole pulses
    task automatic t_gate;
        int d;
        int w;
        set_ctrl(4'h7);
        gate_step(1'h0, d, w);
        cmp(8'(w), 8'(P_HALF));
        follow(36, 1'h0);
        gate_step(1'h1, d, w);
        cmp({7'h0, d >= 2 * P_HALF}, 8'h01);
        cmp(8'(w), 8'(P_HALF));
        set_ctrl(4'h4);
        follow(36, 1'h1);
        $display("gate test done");
    endtask

    task automatic t_float;
        @(posedge clk);
        alt_float <= 1'h1;
        set_ctrl(4'hF);
        follow(24, 1'h1);
        @(posedge clk);
        alt_float <= 1'h0;
        prim_float <= 1'h1;
        set_ctrl(4'hF);
        follow(36, 1'h1);
        $display("float test done");
    endtask

    // Mid-run reset parks the pairs; the gate waits for a rise and fall
    task automatic t_reset;
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        cmp(outs, {4{CMX_PARKED}});
        follow(2 * P_HALF, 1'h0);
        set_ctrl(4'hF);
        follow(36, 1'h1);
        $display("reset test done");
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles
    initial begin
        #100000;
        err_total++;
        stop_test;
    end

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        t_select;
        t_gate;
        t_float;
        t_reset;
        stop_test;
    end
endmodule

`default_nettype wire
